// File: design/gcc_global_clock_control.sv
// global clock control: source selection, network gating, pll reference mux
// assumes config is stable at reset release and all clocks are free running
`timescale 1ns/1ps
module gcc_global_clock_control (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire gcc_pkg::gcc_cfg_s cfg_in,
  input  wire logic [1:0]       clk_pin_in,
  input  wire logic [4:0]       pll_a_cnt_in,
  input  wire logic [4:0]       pll_b_cnt_in,
  input  wire logic             dual_purpose_clock_pin_in,
  input  wire logic             logic_sig_in,
  input  wire logic [1:0]       clk_select_in,
  input  wire logic             net_enable_in,
  input  wire logic             pin_out_enable_in,
  input  wire logic             pll_switch_in,
  input  wire logic             pll_switch_dyn_in,
  output logic                  global_clock_network_out,
  output logic                  pll_ref_out,
  output logic                  pll_ref_valid_out,
  output logic                  first_output_counter_pin_out,
  output logic [1:0]            sel_applied_out,
  output logic                  net_gate_out
);

  gcc_pkg::gcc_cfg_s cfg_ff, nxt_cfg;
  logic              cfg_loaded_ff, nxt_cfg_loaded;
  gcc_pkg::gcc_src_s src;
  logic              dyn_clk;
  logic              sel_clk;
  logic              gate_ff, nxt_gate;
  logic              pin_gate1_ff, nxt_pin_gate1;
  logic              pin_gate2_ff, nxt_pin_gate2;
  logic              pll_switch_sel;

  // instanced once per global network, at most gcc_pkg::BLOCKS_MAX per device

  // configuration is caught by a clock edge after reset release, never by reset itself
  always_comb begin
    nxt_cfg        = cfg_ff;
    nxt_cfg_loaded = cfg_loaded_ff;
    if (!cfg_loaded_ff) begin
      nxt_cfg        = cfg_in;
      nxt_cfg_loaded = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_ff        <= '0;
      cfg_loaded_ff <= 1'b0;
    end else begin
      cfg_ff        <= nxt_cfg;
      cfg_loaded_ff <= nxt_cfg_loaded;
    end
  end

  // two of the four offered counters, first counter index 0 of each pll
  always_comb begin
    logic [9:0] pool;
    pool = {pll_b_cnt_in, pll_a_cnt_in};
    src.clk_pin = cfg_ff.left_side ? 2'h0 : clk_pin_in;
    src.pll_out = {pll_b_cnt_in[cfg_ff.pll_pick1[0]], pll_b_cnt_in[0],
                   pll_a_cnt_in[cfg_ff.pll_pick0[0]], pool[0]};
    src.dual_purpose_clock_pin = dual_purpose_clock_pin_in;
    src.logic_sig = logic_sig_in;
  end

  // dynamic mux covers pins and pll outputs only
  always_comb begin
    case (clk_select_in)
      gcc_pkg::SEL_CLK_PIN0: dyn_clk = src.clk_pin[0];
      gcc_pkg::SEL_CLK_PIN1: dyn_clk = src.clk_pin[1];
      gcc_pkg::SEL_PLL_OUT0: dyn_clk = cfg_ff.pll_pick0[1] ? src.pll_out[1] : src.pll_out[0];
      gcc_pkg::SEL_PLL_OUT1: dyn_clk = cfg_ff.pll_pick1[1] ? src.pll_out[3] : src.pll_out[2];
      default:               dyn_clk = 1'b0;
    endcase
  end

  always_comb begin
    case (cfg_ff.static_src)
      gcc_pkg::GCC_SRC_DYNAMIC:  sel_clk = dyn_clk;
      gcc_pkg::GCC_SRC_DUAL_PIN: sel_clk = src.dual_purpose_clock_pin;
      gcc_pkg::GCC_SRC_LOGIC:    sel_clk = src.logic_sig;
      gcc_pkg::GCC_SRC_OFF:      sel_clk = 1'b0;
      default:                   sel_clk = 1'b0;
    endcase
  end

  // falling-edge latch of the enable keeps high phases whole on the network
  always_comb begin
    nxt_gate = net_enable_in & cfg_ff.net_used;
  end

  always_ff @(negedge sel_clk or posedge rst_in) begin
    if (rst_in) begin
      gate_ff <= gcc_pkg::RST_GATE_EN;
    end else begin
      gate_ff <= nxt_gate;
    end
  end

  // only the network leg is gated; with a dynamic source the pll reference follows it unless pll_switch_sel picks the second pin
  assign global_clock_network_out = sel_clk & gate_ff;

  // two-register enable chain for the dedicated output of the first counter
  always_comb begin
    nxt_pin_gate1 = pin_out_enable_in;
    nxt_pin_gate2 = pin_gate1_ff;
  end

  always_ff @(negedge pll_a_cnt_in[gcc_pkg::FIRST_CNT_IDX] or posedge rst_in) begin
    if (rst_in) begin
      pin_gate1_ff <= gcc_pkg::RST_GATE_EN;
      pin_gate2_ff <= gcc_pkg::RST_GATE_EN;
    end else begin
      pin_gate1_ff <= nxt_pin_gate1;
      pin_gate2_ff <= nxt_pin_gate2;
    end
  end

  assign first_output_counter_pin_out =
    pll_a_cnt_in[gcc_pkg::FIRST_CNT_IDX] & pin_gate2_ff;

  // pll reference mux and the rule on which networks may feed a pll
  always_comb begin
    pll_switch_sel    = cfg_ff.pll_switch_cfg ? pll_switch_dyn_in : pll_switch_in;
    pll_ref_valid_out = (cfg_ff.static_src == gcc_pkg::GCC_SRC_DYNAMIC) && cfg_loaded_ff;
    pll_ref_out       = pll_ref_valid_out &
                        (pll_switch_sel ? src.clk_pin[1] : global_clock_network_out);
  end

  assign sel_applied_out = clk_select_in;
  assign net_gate_out    = gate_ff;

  // assertions in the system clock domain observe the sampled levels
  // they assume source clocks toggle at most once per system cycle

  a_static_logic_path: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_ff.static_src == gcc_pkg::GCC_SRC_LOGIC && gate_ff) |->
      global_clock_network_out == logic_sig_in)
    else $error("logic source not routed");

  a_gate_blocks_clock: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !gate_ff |-> !global_clock_network_out)
    else $error("network clock seen while gated");

  a_pll_ref_source: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_ff.static_src != gcc_pkg::GCC_SRC_DYNAMIC) |-> !pll_ref_out)
    else $error("non pll source drives pll reference");

  a_left_no_pins: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_ff.left_side && cfg_ff.static_src == gcc_pkg::GCC_SRC_DYNAMIC &&
     clk_select_in == gcc_pkg::SEL_CLK_PIN0) |-> !global_clock_network_out)
    else $error("left block passes a pin clock");

  a_left_no_pin1: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_ff.left_side && cfg_ff.static_src == gcc_pkg::GCC_SRC_DYNAMIC &&
     clk_select_in == gcc_pkg::SEL_CLK_PIN1) |-> !global_clock_network_out)
    else $error("left block passes the second pin clock");

  a_cfg_frozen: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    cfg_loaded_ff |=> $stable(cfg_ff))
    else $error("static config changed in user mode");

  a_unused_off: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_loaded_ff && !cfg_ff.net_used) |-> !global_clock_network_out)
    else $error("unused network toggles");

  a_gate_unused: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_loaded_ff && !cfg_ff.net_used) |-> !gate_ff)
    else $error("unused network gate opened");

  a_off_dark: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_ff.static_src == gcc_pkg::GCC_SRC_OFF) |-> !global_clock_network_out)
    else $error("switched off network toggles");

  a_gate_power_up: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    $rose(cfg_loaded_ff) |-> !gate_ff)
    else $error("network gate open at power up");

  a_pin_route: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_ff.static_src == gcc_pkg::GCC_SRC_DYNAMIC && !cfg_ff.left_side && gate_ff &&
     clk_select_in == gcc_pkg::SEL_CLK_PIN1) |-> global_clock_network_out == clk_pin_in[1])
    else $error("select does not route pin");

  a_pin0_route: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_ff.static_src == gcc_pkg::GCC_SRC_DYNAMIC && !cfg_ff.left_side && gate_ff &&
     clk_select_in == gcc_pkg::SEL_CLK_PIN0) |-> global_clock_network_out == clk_pin_in[0])
    else $error("select does not route first pin");

  a_pll0_route: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_ff.static_src == gcc_pkg::GCC_SRC_DYNAMIC && gate_ff &&
     clk_select_in == gcc_pkg::SEL_PLL_OUT0) |->
      global_clock_network_out == (cfg_ff.pll_pick0[1] ? pll_a_cnt_in[cfg_ff.pll_pick0[0]] :
                                   pll_a_cnt_in[0]))
    else $error("select does not route first pll output");

  a_pll1_route: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_ff.static_src == gcc_pkg::GCC_SRC_DYNAMIC && gate_ff &&
     clk_select_in == gcc_pkg::SEL_PLL_OUT1) |->
      global_clock_network_out == (cfg_ff.pll_pick1[1] ? pll_b_cnt_in[cfg_ff.pll_pick1[0]] :
                                   pll_b_cnt_in[0]))
    else $error("select does not route second pll output");

  a_dual_path: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_ff.static_src == gcc_pkg::GCC_SRC_DUAL_PIN && gate_ff) |->
      global_clock_network_out == dual_purpose_clock_pin_in)
    else $error("dual purpose source not routed");

  a_network_and: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    global_clock_network_out == (sel_clk && gate_ff))
    else $error("network clock is not source and gate");

  a_sel_echo: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    sel_applied_out == clk_select_in)
    else $error("applied select differs from request");

  a_ref_valid: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    pll_ref_valid_out == (cfg_ff.static_src == gcc_pkg::GCC_SRC_DYNAMIC && cfg_loaded_ff))
    else $error("pll reference qualifier wrong");

  a_ref_unloaded: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !cfg_loaded_ff |-> !pll_ref_valid_out)
    else $error("pll reference offered before config");

  a_dual_no_ref: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_ff.static_src == gcc_pkg::GCC_SRC_DUAL_PIN) |-> !pll_ref_valid_out)
    else $error("dual purpose network offered to pll");

  a_logic_no_ref: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (cfg_ff.static_src == gcc_pkg::GCC_SRC_LOGIC) |-> !pll_ref_valid_out)
    else $error("logic network offered to pll");

  a_switch_source: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    pll_switch_sel == (cfg_ff.pll_switch_cfg ? pll_switch_dyn_in : pll_switch_in))
    else $error("pll switch control from wrong source");

  a_ref_network: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (pll_ref_valid_out && !pll_switch_sel) |-> pll_ref_out == global_clock_network_out)
    else $error("pll reference is not the network");

  a_ref_pin: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (pll_ref_valid_out && pll_switch_sel && !cfg_ff.left_side) |->
      pll_ref_out == clk_pin_in[1])
    else $error("pll reference is not the switched pin");

  a_pin_gate_chain: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !pin_gate2_ff |-> !first_output_counter_pin_out)
    else $error("first counter pin ungated");

  a_pin_gate_stages: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    $changed(pin_gate2_ff) |-> pin_gate2_ff == $past(pin_gate1_ff))
    else $error("pin enable skipped a stage");

  a_pin_pass: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    pin_gate2_ff |-> first_output_counter_pin_out == pll_a_cnt_in[gcc_pkg::FIRST_CNT_IDX])
    else $error("first counter not passed to pin");

  a_pin_first_only: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    first_output_counter_pin_out |-> pll_a_cnt_in[gcc_pkg::FIRST_CNT_IDX])
    else $error("pin driven by other than first counter");

  c_dynamic_pll: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    gate_ff && clk_select_in == gcc_pkg::SEL_PLL_OUT0);
  c_gate_off: cover property (@(posedge clk_sys_in) disable iff (rst_in) $fell(gate_ff));
  c_gate_on: cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(gate_ff));
  c_dual_pin: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    cfg_ff.static_src == gcc_pkg::GCC_SRC_DUAL_PIN && gate_ff);
  c_pll_switch: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    pll_ref_valid_out && pll_switch_sel);

endmodule : gcc_global_clock_control

// File: include/gcc_pkg.sv
// package for the global clock control block: source codes, static selection, carriers
// assumes one block per global clock network, six candidate sources
package gcc_pkg;

  localparam int unsigned NUM_PLL_OFFERED  = 4;
  localparam int unsigned NUM_PLL_COUNTERS = 5;
  localparam int unsigned SIDE_CLK_PINS    = 4;
  localparam int unsigned SIDE_PLL_OUTS    = 10;
  localparam int unsigned SIDE_LOGIC_SIGS  = 5;
  localparam int unsigned BLOCKS_MAX       = 30;
  localparam int unsigned FIRST_CNT_IDX    = 0;

  localparam logic [1:0] SEL_CLK_PIN0 = 2'h0;
  localparam logic [1:0] SEL_CLK_PIN1 = 2'h1;
  localparam logic [1:0] SEL_PLL_OUT0 = 2'h2;
  localparam logic [1:0] SEL_PLL_OUT1 = 2'h3;

  localparam logic       RST_GATE_EN  = 1'b0;

  typedef enum logic [1:0] {
    GCC_SRC_DYNAMIC,
    GCC_SRC_DUAL_PIN,
    GCC_SRC_LOGIC,
    GCC_SRC_OFF
  } gcc_static_src_e;

  // configuration image, loaded once at reset release
  typedef struct packed {
    gcc_static_src_e static_src;
    logic            left_side;
    logic            net_used;
    logic [1:0]      pll_pick0;
    logic [1:0]      pll_pick1;
    logic            pll_switch_cfg;
  } gcc_cfg_s;

  typedef struct packed {
    logic [1:0] clk_pin;
    logic [3:0] pll_out;
    logic       dual_purpose_clock_pin;
    logic       logic_sig;
  } gcc_src_s;

endpackage : gcc_pkg

// File: tb/gcc_fabric_model.sv
// fabric-side model: drives the dynamic select and the network enable
// assumes one switch request at a time, none before reset is released
`timescale 1ns/1ps
module gcc_fabric_model #(
  parameter int WAIT_CYC = 16
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       req_in,
  input  wire logic [1:0] req_sel_in,
  input  wire logic       hold_in,
  output logic [1:0]      sel_out,
  output logic            en_out,
  output logic            busy_out
);
  logic [7:0] cnt_ff;
  logic       en_ff;
  // disable first, then switch, let the new source run a while, re-enable
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff  <= 8'h00;
      en_ff   <= 1'b0;
      sel_out <= 2'h0;
    end else if (req_in) begin
      en_ff  <= 1'b0;
      cnt_ff <= 8'h01;
    end else if (cnt_ff == 8'h01) begin
      sel_out <= req_sel_in;
      cnt_ff  <= 8'h02;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= (cnt_ff == 8'(WAIT_CYC)) ? 8'h00 : cnt_ff + 8'h01;
      en_ff  <= (cnt_ff == 8'(WAIT_CYC));
    end
  end
  // hold keeps the network dark while a pll settles
  assign en_out   = en_ff & ~hold_in;
  assign busy_out = (cnt_ff != 8'h00);
endmodule : gcc_fabric_model

// File: tb/gcc_global_clock_control_bench.sv
// testbench for the global clock control block with a fabric model
// assumes source clocks are slow divisions of the system clock
`timescale 1ns/1ps
module gcc_global_clock_control_bench;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, pin_out_enable_in = 1'b0, pll_switch_in = 1'b0;
  logic pll_switch_dyn_in = 1'b0, req = 1'b0, hold = 1'b0, busy, net_enable_in, net_gate_out;
  logic global_clock_network_out, pll_ref_out, pll_ref_valid_out, first_output_counter_pin_out;
  logic [1:0] clk_select_in, sel_applied_out, req_sel = 2'h0;
  logic [7:0] sc = 8'h00;
  gcc_pkg::gcc_cfg_s cfg_in = '0;
  int mismatches = 0, num_checks = 0;
  wire logic [1:0] clk_pin_in = sc[2:1];
  wire logic [4:0] pll_a_cnt_in = sc[7:3];
  wire logic [4:0] pll_b_cnt_in = {4'h0, sc[0]};
  wire logic dual_purpose_clock_pin_in = sc[4];
  wire logic logic_sig_in = sc[5];
  wire logic [3:0] srcs = {sc[0], sc[3], sc[2], sc[1]};
  gcc_global_clock_control u_dut (.clk_sys_in, .rst_in, .cfg_in, .clk_pin_in, .pll_a_cnt_in,
    .pll_b_cnt_in, .dual_purpose_clock_pin_in, .logic_sig_in, .clk_select_in, .net_enable_in,
    .pin_out_enable_in, .pll_switch_in, .pll_switch_dyn_in, .global_clock_network_out,
    .pll_ref_out, .pll_ref_valid_out, .first_output_counter_pin_out, .sel_applied_out,
    .net_gate_out);
  gcc_fabric_model #(.WAIT_CYC(16)) u_fab (.clk_sys_in, .rst_in, .req_in(req),
    .req_sel_in(req_sel), .hold_in(hold), .sel_out(clk_select_in), .en_out(net_enable_in),
    .busy_out(busy));
  initial forever #5 clk_sys_in = ~clk_sys_in;
  // sources move on the falling system edge so fabric inputs never race them
  always @(negedge clk_sys_in) sc <= sc + 8'h01;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic smp(input int n);
    repeat (n) @(posedge clk_sys_in);
    #2;
  endtask : smp
  function automatic gcc_pkg::gcc_cfg_s mk(gcc_pkg::gcc_static_src_e s, logic left);
    mk = '{s, left, 1'b1, 2'h0, 2'h0, 1'b0};
  endfunction : mk
  task automatic restart(input gcc_pkg::gcc_cfg_s c);
    @(posedge clk_sys_in) rst_in <= 1'b1;
    cfg_in <= c;
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    smp(2);
  endtask : restart
  task automatic switch_to(input logic [1:0] s);
    @(posedge clk_sys_in) req <= 1'b1;
    req_sel <= s;
    @(posedge clk_sys_in) req <= 1'b0;
    smp(1);
    for (int i = 0; i < 40 && busy; i++) smp(1);
    smp(17);
  endtask : switch_to
  task automatic t_dark(input gcc_pkg::gcc_cfg_s c);
    restart(c);
    switch_to(2'h0);
    repeat (8) begin
      smp(3);
      check(global_clock_network_out, 8'h00);
    end
  endtask : t_dark
  task automatic t_dynamic;
    restart(mk(gcc_pkg::GCC_SRC_DYNAMIC, 1'b0));
    for (int s = 0; s < 4; s++) begin
      switch_to(s[1:0]);
      check(sel_applied_out, 8'(s));
      check(pll_ref_valid_out, 8'h01);
      repeat (12) begin
        smp(3);
        check(global_clock_network_out, srcs[s]);
        check(pll_ref_out, global_clock_network_out);
      end
    end
    @(posedge clk_sys_in) pll_switch_in <= 1'b1;
    smp(1);
    check(pll_ref_out, sc[2]);
  endtask : t_dynamic
  task automatic t_gate;
    switch_to(2'h0);
    do @(posedge clk_sys_in); while (sc[1:0] != 2'h1);
    hold <= 1'b1;
    // the source is still high for two samples; the gate may only close at its fall
    repeat (2) begin
      smp(1);
      check(global_clock_network_out, 8'h01);
    end
    repeat (8) begin
      smp(1);
      check({global_clock_network_out, net_gate_out}, 8'h00);
    end
    @(posedge clk_sys_in) hold <= 1'b0;
    smp(5);
    repeat (8) begin
      smp(1);
      check(global_clock_network_out, sc[1]);
    end
  endtask : t_gate
  task automatic t_pin;
    @(posedge clk_sys_in) pin_out_enable_in <= 1'b1;
    smp(34);
    repeat (12) begin
      smp(3);
      check(first_output_counter_pin_out, sc[3]);
    end
    @(posedge clk_sys_in) pin_out_enable_in <= 1'b0;
    smp(34);
    check(first_output_counter_pin_out, 8'h00);
  endtask : t_pin
  task automatic t_static;
    for (int k = 0; k < 2; k++) begin
      restart(mk(k ? gcc_pkg::GCC_SRC_DUAL_PIN : gcc_pkg::GCC_SRC_LOGIC, 1'b0));
      switch_to(2'h2);
      // slow static sources: the gate opens only at their next falling edge
      for (int i = 0; i < 80 && !net_gate_out; i++) smp(1);
      check(net_gate_out, 8'h01);
      repeat (12) begin
        smp(3);
        check(global_clock_network_out, k ? sc[4] : sc[5]);
        check({pll_ref_valid_out, pll_ref_out}, 8'h00);
      end
    end
  endtask : t_static
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    mismatches++;
    print_verdict();
  end
  initial begin
    t_dark('0);
    t_dynamic();
    t_gate();
    t_pin();
    t_static();
    t_dark(mk(gcc_pkg::GCC_SRC_DYNAMIC, 1'b1));
    print_verdict();
  end
endmodule : gcc_global_clock_control_bench
